// ===== rtl/ebvc_consts.svh
// constants for the external bus visibility controller
// assumes the includer uses these as plain widths, codes and counts
`ifndef EBVC_CONSTS_SVH
`define EBVC_CONSTS_SVH

`define EBVC_ADDR_W        16
`define EBVC_DATA_W        16
`define EBVC_MODE_W        3
// mode_select_bits encodings
`define EBVC_MODE_SPEC_SC  3'h0
`define EBVC_MODE_EMU_NAR  3'h1
`define EBVC_MODE_PERIPH   3'h2
`define EBVC_MODE_EMU_WIDE 3'h3
`define EBVC_MODE_NORM_SC  3'h4
`define EBVC_MODE_NORM_NAR 3'h5
`define EBVC_MODE_SPEC_TST 3'h6
`define EBVC_MODE_NORM_WID 3'h7
// reset values
`define EBVC_RST_VIS_EN    1'b0
`define EBVC_RST_ADDR      16'h0000
`define EBVC_RST_DATA      16'h0000

`endif

// ===== rtl/ebvc_pkg.sv
// types for the external bus visibility controller
// assumes ebvc_consts.svh is on the include path
`include "ebvc_consts.svh"

package ebvc_pkg;

    // one internal core bus cycle as seen by the pin logic
    typedef struct packed {
        logic                      valid;    // a core cycle is present
        logic                      internal; // targets an internal resource
        logic                      no_access;// processor free cycle
        logic                      debug_sel;// background_debug_unit selected
        logic                      debug_drv;// background_debug_unit drives
        logic                      write;    // write cycle
        logic                      low_byte; // low byte access
        logic [`EBVC_ADDR_W-1:0]   addr;     // cycle address
        logic [`EBVC_DATA_W-1:0]   data;     // cycle data
    } ebvc_cycle_type;

    // external pin values
    typedef struct packed {
        logic                      eclk;            // bus clock
        logic                      rd_wr;           // high = read
        logic                      low_byte_strobe; // active low
        logic [`EBVC_ADDR_W-1:0]   addr;            // address
        logic [`EBVC_DATA_W-1:0]   data;            // data
    } ebvc_pins_type;

    typedef enum logic [2:0] {
        EBVC_RUN  = 3'b001,
        EBVC_TEST = 3'b010,
        EBVC_HALT = 3'b100
    } ebvc_state_type;

endpackage

// ===== rtl/ebvc_mode_ctrl.sv
// operating-mode control: mode_select_bits and visibility_enable storage
// assumes writes come from the core on sys_clk, one cycle strobe
`timescale 1ns/10ps
`include "ebvc_consts.svh"

module ebvc_mode_ctrl
    import ebvc_pkg::*;
(
    input  wire logic                    sys_clk,      // core clock
    input  wire logic                    resetn,       // sync reset, low
    input  wire logic [`EBVC_MODE_W-1:0] strap_mode,   // mode latched at reset
    input  wire logic                    secured,      // chip secured
    input  wire logic                    mode_wr,      // mode register write
    input  wire logic [`EBVC_MODE_W-1:0] mode_wr_sel,  // new mode_select_bits
    input  wire logic                    mode_wr_vis,  // new visibility_enable
    output      logic [`EBVC_MODE_W-1:0] mode_select_bits, // current mode
    output      logic                    visibility_enable // stored enable
);

    logic [`EBVC_MODE_W-1:0] next_mode_select_bits;
    logic                    next_visibility_enable;
    logic                    periph;

    assign periph = (mode_select_bits == `EBVC_MODE_PERIPH);

    always_comb begin
        next_mode_select_bits  = mode_select_bits;
        next_visibility_enable = visibility_enable;
        // register unreachable in tester mode; only a reset leaves it
        if (mode_wr && !periph) begin
            next_visibility_enable = mode_wr_vis;
            if (!secured) begin
                next_mode_select_bits = mode_wr_sel;
            end
        end
    end

    // strap taken on a clocked edge while reset is held, never asynchronously
    always_ff @(posedge sys_clk) begin
        if (!resetn) begin
            mode_select_bits  <= strap_mode;
            visibility_enable <= `EBVC_RST_VIS_EN;
        end else begin
            mode_select_bits  <= next_mode_select_bits;
            visibility_enable <= next_visibility_enable;
        end
    end

endmodule

// ===== rtl/ebvc_top.sv
// external bus pin conduct for internal, debug and no-access cycles
// assumes core cycle info arrives on sys_clk; pins are sampled outside
`timescale 1ns/10ps
`include "ebvc_consts.svh"

module ebvc_top
    import ebvc_pkg::*;
(
    input  wire logic                    sys_clk,         // 125 MHz core clock
    input  wire logic                    resetn,          // sync reset, low
    input  wire logic [`EBVC_MODE_W-1:0] strap_mode_pin,  // mode pins
    input  wire logic                    secured,         // security state
    input  wire logic                    mode_wr,         // mode register write
    input  wire logic [`EBVC_MODE_W-1:0] mode_wr_sel,     // written mode bits
    input  wire logic                    mode_wr_vis,     // written enable
    input  wire logic                    stop_exec,       // stop executed
    input  wire logic                    stop_wake,       // stop wakeup
    input  wire logic                    wait_mode,       // wait mode, no effect
    input  wire ebvc_cycle_type          cycle,           // core cycle
    input  wire logic                    eclk_phase,      // core bus phase
    input  wire logic [1:0]              pipe_status,     // core pipe status
    input  wire logic                    pipe_en,         // pipe outputs on
    input  wire logic [3:0]              port_e_assignment, // ctrl enables
    output      ebvc_pins_type           pins,            // bus pin values
    output      logic                    bus_oe,          // address/data drive
    output      logic [3:0]              ctrl_oe,         // rw,strb,eclk,pipe
    output      logic [1:0]              pipe_status_outputs, // pipe pins
    output      logic                    core_hold,       // idle the core
    output      logic [`EBVC_MODE_W-1:0] mode_select_bits, // current mode
    output      logic                    vis_active       // visibility live
);

    ////////////////////////////////////////////////////////////////////
    // strap synchroniser
    logic [`EBVC_MODE_W-1:0] strap_s1;
    logic [`EBVC_MODE_W-1:0] strap_s2;

    always_ff @(posedge sys_clk) begin
        strap_s1 <= strap_mode_pin;
        strap_s2 <= strap_s1;
    end

    logic visibility_enable;

    ebvc_mode_ctrl u_mode (
        .sys_clk           (sys_clk),
        .resetn            (resetn),
        .strap_mode        (strap_s2),
        .secured           (secured),
        .mode_wr           (mode_wr),
        .mode_wr_sel       (mode_wr_sel),
        .mode_wr_vis       (mode_wr_vis),
        .mode_select_bits  (mode_select_bits),
        .visibility_enable (visibility_enable)
    );

    ////////////////////////////////////////////////////////////////////
    // mode decode
    logic periph;
    logic single_chip;
    logic emu_exp;
    logic vis_allowed;

    assign periph      = (mode_select_bits == `EBVC_MODE_PERIPH);
    assign single_chip = (mode_select_bits == `EBVC_MODE_SPEC_SC)
                       || (mode_select_bits == `EBVC_MODE_NORM_SC);
    assign emu_exp     = (mode_select_bits == `EBVC_MODE_EMU_NAR)
                       || (mode_select_bits == `EBVC_MODE_EMU_WIDE);
    assign vis_allowed = (mode_select_bits == `EBVC_MODE_EMU_WIDE)
                       || (mode_select_bits == `EBVC_MODE_NORM_WID)
                       || (mode_select_bits == `EBVC_MODE_SPEC_TST)
                       || (mode_select_bits == `EBVC_MODE_EMU_NAR);

    // not-allowed modes and security both read the enable as clear
    assign vis_active = visibility_enable && vis_allowed && !secured;

    ////////////////////////////////////////////////////////////////////
    // run / tester / halted state
    ebvc_state_type state;
    ebvc_state_type next_state;

    always_comb begin
        next_state = state;
        case (state)
            EBVC_RUN: begin
                if (periph) begin
                    next_state = EBVC_TEST;
                end else if (stop_exec) begin
                    next_state = EBVC_HALT;
                end
            end
            EBVC_TEST: begin
                next_state = EBVC_TEST;
            end
            EBVC_HALT: begin
                if (stop_wake) begin
                    next_state = EBVC_RUN;
                end
            end
            default: begin
                next_state = EBVC_RUN;
            end
        endcase
    end

    always_ff @(posedge sys_clk) begin
        if (!resetn) begin
            state <= EBVC_RUN;
        end else begin
            state <= next_state;
        end
    end

    // tester drives the pins; background debug stays off by its promise
    // mode term covers the first cycle after reset, before state moves
    assign core_hold = (state == EBVC_TEST) || periph;

    ////////////////////////////////////////////////////////////////////
    // pin values; wait_mode deliberately unused in the pin path
    ebvc_pins_type next_pins;
    logic [1:0]    next_pipe;
    logic          active;
    logic          hidden_int;
    logic          rw_en;
    logic          strb_en;
    logic          eclk_en;
    logic          pipe_pin_en;

    assign active = (state == EBVC_RUN) && !single_chip && !periph;

    // emulation expanded forces all bus control pins on
    assign rw_en       = emu_exp || port_e_assignment[0];
    assign strb_en     = emu_exp || port_e_assignment[1];
    assign eclk_en     = emu_exp || port_e_assignment[2];
    assign pipe_pin_en = emu_exp || (port_e_assignment[3] && pipe_en);

    assign hidden_int = cycle.valid && cycle.internal && !vis_active;

    always_comb begin
        next_pins       = pins;
        next_pins.eclk  = 1'b0;
        next_pipe       = secured ? 2'b00 : pipe_status;
        if (active && cycle.valid) begin
            next_pins.eclk = eclk_phase;
            if (hidden_int) begin
                // rw only forced when configured as an output
                next_pins.eclk  = 1'b0;
                next_pins.rd_wr = rw_en ? 1'b1 : pins.rd_wr;
            end else if (cycle.debug_sel && vis_active) begin
                next_pins.rd_wr = 1'b1;
                next_pins.addr  = cycle.addr;
                next_pins.low_byte_strobe = !cycle.low_byte;
            end else if (cycle.no_access && !cycle.debug_drv) begin
                next_pins.rd_wr = 1'b1;
            end else begin
                next_pins.rd_wr = !cycle.write;
                next_pins.addr  = cycle.addr;
                next_pins.data  = cycle.data;
                next_pins.low_byte_strobe = !cycle.low_byte;
            end
        end
        // single chip leaves the address latch frozen to save toggling
        if (single_chip) begin
            next_pins.addr = pins.addr;
        end
    end

    always_ff @(posedge sys_clk) begin
        if (!resetn) begin
            pins.eclk            <= 1'b0;
            pins.rd_wr           <= 1'b1;
            pins.low_byte_strobe <= 1'b1;
            pins.addr            <= `EBVC_RST_ADDR;
            pins.data            <= `EBVC_RST_DATA;
            pipe_status_outputs  <= 2'b00;
        end else begin
            pins                <= next_pins;
            pipe_status_outputs <= next_pipe;
        end
    end

    ////////////////////////////////////////////////////////////////////
    // output enables: tester mode and single chip release the bus
    assign bus_oe  = active;
    // emulation keeps control pins driven even while halted
    assign ctrl_oe = emu_exp ? 4'hf
                   : {pipe_pin_en && (state != EBVC_HALT),
                      eclk_en && (state != EBVC_TEST) && !periph,
                      strb_en && active,
                      rw_en && active};

endmodule

// ===== tb/ebvc_top_assertions.sv
// checker for pin conduct of the bus visibility block
// assumes only the top ports are seen; bound to ebvc_top at the foot
`timescale 1ns/10ps
`include "ebvc_consts.svh"

module ebvc_top_checker
    import ebvc_pkg::*;
(
    input wire logic                    sys_clk,             // clock
    input wire logic                    resetn,              // sync reset, low
    input wire logic                    secured,             // security state
    input wire logic                    mode_wr,             // mode write
    input wire logic                    stop_exec,           // stop executed
    input wire logic                    stop_wake,           // stop wakeup
    input wire ebvc_cycle_type          cycle,               // core cycle
    input wire ebvc_pins_type           pins,                // pin values
    input wire logic                    bus_oe,              // bus drive
    input wire logic [3:0]              ctrl_oe,             // control drive
    input wire logic [1:0]              pipe_status_outputs, // pipe pins
    input wire logic                    core_hold,           // core idle
    input wire logic [`EBVC_MODE_W-1:0] mode_select_bits,    // mode
    input wire logic                    vis_active           // visibility live
);
    default clocking @(posedge sys_clk); endclocking
    default disable iff (!resetn);
    logic halted;
    logic next_halted;
    logic single_chip;
    logic quiet;
    assign single_chip = mode_select_bits inside {`EBVC_MODE_SPEC_SC, `EBVC_MODE_NORM_SC};
    // halt, tester mode and single chip freeze pins, so pin rules only hold outside them
    assign quiet = halted || stop_exec || core_hold || single_chip;
    always_comb begin
        next_halted = stop_exec ? 1'b1 : (stop_wake ? 1'b0 : halted);
    end
    always_ff @(posedge sys_clk) begin
        halted <= resetn ? next_halted : 1'b0;
    end
    sequence s_stop_held;
        (stop_exec && !stop_wake) ##1 !stop_wake ##1 !stop_wake;
    endsequence
    ////////////////////////////////////////////////////////////////////////
    a_tester_idle: assert property (mode_select_bits == `EBVC_MODE_PERIPH |-> core_hold)
        else $error("core not idle in tester mode");
    a_vis_modes: assert property (vis_active |-> mode_select_bits inside {`EBVC_MODE_EMU_NAR,
        `EBVC_MODE_EMU_WIDE, `EBVC_MODE_SPEC_TST, `EBVC_MODE_NORM_WID})
        else $error("visibility in a mode without it");
    a_secure_novis: assert property (secured |-> !vis_active)
        else $error("visibility while secured");
    a_hidden_hold: assert property (cycle.valid && cycle.internal && !vis_active && !quiet
        |=> !pins.eclk && {pins.addr, pins.data, pins.low_byte_strobe} ==
        $past({pins.addr, pins.data, pins.low_byte_strobe}))
        else $error("hidden internal cycle moved the pins");
    a_debug_cycle: assert property (cycle.valid && cycle.debug_sel && vis_active && !quiet
        |=> pins.rd_wr && pins.data == $past(pins.data) && pins.addr == $past(cycle.addr))
        else $error("debug cycle pins wrong");
    a_noacc_hold: assert property (cycle.valid && cycle.no_access && !cycle.debug_drv
        && !cycle.debug_sel && vis_active && !quiet |=> pins.rd_wr
        && {pins.addr, pins.data} == $past({pins.addr, pins.data}))
        else $error("free cycle moved the pins");
    a_pipe_hidden: assert property (secured ##1 secured |-> pipe_status_outputs == 2'h0)
        else $error("pipe status shown while secured");
    a_mode_locked: assert property (mode_wr && (secured || core_hold)
        |=> $stable(mode_select_bits))
        else $error("locked mode bits changed");
    a_stop_freeze: assert property (s_stop_held |=> $stable(pins))
        else $error("pins moved after stop");
    a_single_quiet: assert property (single_chip ##1 single_chip |-> !bus_oe
        && $stable(pins.addr))
        else $error("address toggles in single chip");
    a_emu_ctrl: assert property (mode_select_bits inside {`EBVC_MODE_EMU_NAR,
        `EBVC_MODE_EMU_WIDE} |-> ctrl_oe == 4'hf)
        else $error("emulation control pins not driven");
endmodule

bind ebvc_top ebvc_top_checker u_ebvc_top_checker (.sys_clk, .resetn, .secured, .mode_wr,
    .stop_exec, .stop_wake, .cycle, .pins, .bus_oe, .ctrl_oe, .pipe_status_outputs,
    .core_hold, .mode_select_bits, .vis_active);

// ===== tb/ebvc_ext_model.sv
// external address latch watching the bus pins
// assumes it latches the address on a rising bus clock while driven
`timescale 1ns/10ps
`include "ebvc_consts.svh"

module ebvc_ext_model
    import ebvc_pkg::*;
(
    input  wire logic                    sys_clk,   // clock
    input  wire ebvc_pins_type           pins,      // bus pins
    input  wire logic                    bus_oe,    // bus driven
    output      logic [`EBVC_ADDR_W-1:0] seen_addr  // last latched address
);
    logic eclk_q = 1'b0;
    initial seen_addr = 16'h0000;
    // hidden cycles keep the bus clock low, so nothing is latched
    always @(posedge sys_clk) begin
        eclk_q <= pins.eclk;
        if (bus_oe && pins.eclk && !eclk_q) begin
            seen_addr <= pins.addr;
        end
    end
endmodule

// ===== tb/ebvc_top_bench.sv
// self-checking bench for the bus visibility block
// assumes 125 MHz clock; inputs change at the falling edge
`timescale 1ns/10ps
`include "ebvc_consts.svh"
`define CHK(g, e) begin comparisons++; if ((g) !== (e)) begin miscompares++; \
    $display("wrong value at %0t: got %h expected %h", $time, g, e); end end

module ebvc_top_bench
    import ebvc_pkg::*;
;
    logic sys_clk = 0, resetn = 0, secured = 0, mode_wr = 0, mode_wr_vis = 0;
    logic stop_exec = 0, stop_wake = 0, wait_mode = 0, pipe_en = 1, eclk_phase = 1;
    logic [2:0] strap = 3'h0, mode_wr_sel = 3'h0, mode;
    logic [1:0] pipe_status = 2'h3, pipe_out;
    logic [3:0] pe = 4'hf, ctrl_oe;
    logic [15:0] seen_addr;
    logic bus_oe, core_hold, vis_active;
    ebvc_cycle_type cyc = '0;
    ebvc_pins_type pins;
    int miscompares = 0, comparisons = 0;
    always #4 sys_clk = ~sys_clk;
    ebvc_top u_ebvc_top (.sys_clk, .resetn, .strap_mode_pin(strap), .secured, .mode_wr,
        .mode_wr_sel, .mode_wr_vis, .stop_exec, .stop_wake, .wait_mode, .cycle(cyc),
        .eclk_phase, .pipe_status, .pipe_en, .port_e_assignment(pe), .pins, .bus_oe,
        .ctrl_oe, .pipe_status_outputs(pipe_out), .core_hold, .mode_select_bits(mode),
        .vis_active);
    ebvc_ext_model u_ebvc_ext_model (.sys_clk, .pins, .bus_oe, .seen_addr);
    ////////////////////////////////////////////////////////////////////////
    task end_sim;
        $display("comparisons %0d miscompares %0d", comparisons, miscompares);
        if (miscompares == 0 && comparisons > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask
    task reset_into(input logic [2:0] m);
        strap = m;
        resetn = 0;
        repeat (3) @(negedge sys_clk);
        resetn = 1;
    endtask
    task wr_mode(input logic [2:0] s, input logic v);
        cyc.valid = 1'b0;
        {mode_wr, mode_wr_sel, mode_wr_vis} = {1'b1, s, v};
        @(negedge sys_clk);
        mode_wr = 0;
        @(negedge sys_clk);
    endtask
    // kind is {internal, no_access, debug_sel, debug_drv}; pins answer one edge later
    task bus(input logic [3:0] k, input logic [15:0] a, d, input logic w, lb);
        cyc = {1'b1, k, w, lb, a, d};
        @(negedge sys_clk);
    endtask
    initial begin
        #200000;
        miscompares++;
        end_sim();
    end
    initial begin
        @(negedge sys_clk);
        reset_into(`EBVC_MODE_EMU_WIDE);
        wr_mode(`EBVC_MODE_EMU_WIDE, 1);
        bus(4'h8, 16'h1234, 16'habcd, 1, 0);
        `CHK(pins.addr, 16'h1234)
        `CHK({pins.rd_wr, pins.low_byte_strobe, pipe_out}, 4'h7)
        wr_mode(`EBVC_MODE_EMU_WIDE, 0);
        bus(4'h8, 16'h5555, 16'h0000, 1, 1);
        `CHK({pins.eclk, pins.rd_wr, pins.low_byte_strobe, pins.addr, pins.data}, 35'h3_1234_abcd)
        `CHK(seen_addr, 16'h1234)
        wr_mode(`EBVC_MODE_EMU_WIDE, 1);
        bus(4'h2, 16'h2222, 16'h9999, 1, 1);
        `CHK({pins.rd_wr, pins.low_byte_strobe, pins.addr, pins.data}, 34'h2_2222_abcd)
        bus(4'h4, 16'h3333, 16'h0000, 1, 0);
        `CHK({pins.rd_wr, pins.low_byte_strobe, pins.addr, pins.data}, 34'h2_2222_abcd)
        wait_mode = 1;
        bus(4'h8, 16'h4444, 16'h0000, 0, 0);
        `CHK(pins.addr, 16'h4444)
        {wait_mode, stop_exec} = 2'b01;
        @(negedge sys_clk);
        stop_exec = 0;
        bus(4'h8, 16'h6666, 16'h0000, 0, 0);
        `CHK(pins.addr, 16'h4444)
        @(negedge sys_clk);
        stop_wake = 1;
        @(negedge sys_clk);
        stop_wake = 0;
        bus(4'h8, 16'h6666, 16'h0000, 0, 0);
        `CHK(pins.addr, 16'h6666)
        secured = 1;
        bus(4'h8, 16'h7777, 16'h0000, 0, 0);
        `CHK({pins.eclk, pins.addr, vis_active}, 18'h0_cccc)
        `CHK(pipe_out, 2'h0)
        wr_mode(`EBVC_MODE_NORM_WID, 1);
        `CHK(mode, `EBVC_MODE_EMU_WIDE)
        secured = 0;
        pe = 4'h0;
        $display("test pin conduct done");
        for (int m = 0; m < 8; m++) begin
            reset_into(m[2:0]);
            wr_mode(m[2:0], 1);
            `CHK(vis_active, 8'b1100_1010 >> m & 8'h01 ? 1'b1 : 1'b0)
            `CHK(core_hold, m == 2)
            if (m == 0 || m == 4) `CHK(bus_oe, 1'b0)
            else `CHK(bus_oe, m != 2)
            if (m == 1 || m == 3) `CHK(ctrl_oe, 4'hf)
            else `CHK(ctrl_oe, 4'h0)
        end
        reset_into(`EBVC_MODE_PERIPH);
        wr_mode(`EBVC_MODE_EMU_WIDE, 0);
        `CHK(mode, `EBVC_MODE_PERIPH)
        $display("test mode table done");
        end_sim();
    end
endmodule
